// [rtl/fsps_pkg.sv]
// package: constants, types and register map of the flash self-program sequencer
`default_nettype none
package fsps_pkg;

   // ************************************************************
   // register map (index on the plain register port)
   // ************************************************************
   localparam int          REG_AW        = 3;
   localparam logic [2:0]  REG_PTR_LOW   = 3'h0;   // pointer_low_byte
   localparam logic [2:0]  REG_PTR_HIGH  = 3'h1;   // pointer bits 15:8
   localparam logic [2:0]  REG_PTR_UPPER = 3'h2;   // pointer bits 21:16
   localparam logic [2:0]  REG_LATCH     = 3'h3;   // table_latch
   localparam logic [2:0]  REG_CTRL      = 3'h4;   // flash_control_reg
   localparam logic [2:0]  REG_KEY       = 3'h5;   // unlock_key_reg, reads zero

   // ************************************************************
   // flash_control_reg fields
   // ************************************************************
   localparam int CTRL_ERASE_SEL = 4;              // erase-select
   localparam int CTRL_WR_ERR    = 3;              // write_error_flag
   localparam int CTRL_WR_EN     = 2;              // write_enable_bit
   localparam int CTRL_WR_START  = 1;              // write-start

   // ************************************************************
   // unlock keys, pointer and array geometry
   // ************************************************************
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'haa;
   localparam int         PTR_W       = 22;        // full pointer width
   localparam int         PTR_UPD_W   = 21;        // bits touched by auto update
   localparam int         PTR_UP_W    = 6;         // upper byte implemented bits
   localparam int         HOLD_N      = 64;        // holding registers (bytes)
   localparam int         HOLD_AW     = 6;         // holding register index width
   localparam int         ERASE_LSB   = 10;        // 1024-byte block boundary
   localparam int         WORD_AW     = 21;        // 16-bit word address width

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ     = 50;                // sys_clk rate
   localparam int TIMER_W     = 24;                // long write timer width

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      PTR_KEEP,                                    // pointer unchanged
      PTR_POST_INC,                                // increment after access
      PTR_POST_DEC,                                // decrement after access
      PTR_PRE_INC                                  // increment before access
   } fsps_ptr_mode_t;

   typedef struct packed {
      logic           rd;                          // table_read_op pulse
      logic           wr;                          // table_write_op pulse
      fsps_ptr_mode_t mode;                        // pointer update mode
   } fsps_tbl_op_t;

   typedef struct packed {
      logic                  prog;                 // one holding byte to array
      logic                  erase;                // erase one block
      logic [PTR_W-1:0]      addr;                 // byte / block base address
      logic [7:0]            data;                 // byte to program
   } fsps_flash_wr_t;

endpackage : fsps_pkg
`default_nettype wire

// [rtl/fsps_sequencer.sv]
// module: flash self-program sequencer with table read/write and timed long writes
//
// Contract
// - table read puts one pointed byte into latch
// - table read may auto-update the pointer
// - address bit 0 picks low or high byte
// - erase always clears a whole 1024-byte block
// - no bulk erase from own sequence
// - erase block from pointer bits 21:10
// - long write refused without write-enable
// - erase-select chooses erase, else program
// - unlock sequence required before long write
// - valid start begins cycle at once
// - core stalled for whole long write
// - internal timer ends every long write not cut short by abortReq
// - programming covers a 64-byte block unless abortReq cuts the stream short
// - sixty-four byte holding registers loaded by table writes
// - table writes touch only holding registers, no stall
// - holding registers kept after programming
// - write-start set only by software, hardware clears
// - premature end or bad attempt sets error flag
// - pointer low six bits pick holding register
// - four pointer modes, only low 21 bits
`default_nettype none
module fsps_sequencer
   import fsps_pkg::*;
#(
   parameter int PROG_TIME_US  = 1000,            // programming duration, us
   parameter int ERASE_TIME_US = 1000             // erase_duration, us
) (
   // clock and reset
   input  wire  logic                 sys_clk,
   input  wire  logic                 arst_n,
   // register port
   input  wire  logic [REG_AW-1:0]    regAddr,
   input  wire  logic [7:0]           regWrData,
   input  wire  logic                 regWr,
   input  wire  logic                 regRd,
   output var   logic [7:0]           regRdData_r,
   // table operations from the core
   input  wire  fsps_tbl_op_t         tblOp,
   output var   logic                 coreStall_r,
   // warm reset that aborts a running long write
   input  wire  logic                 abortReq,
   // flash array side
   output var   logic                 flashRdEn_r,
   output var   logic [WORD_AW-1:0]   flashRdAddr_r,
   input  wire  logic [15:0]          flashRdData,
   output var   fsps_flash_wr_t       flashWr_r
);

   // ************************************************************
   // derived timing counts
   // ************************************************************
   localparam int PROG_CYC  = (PROG_TIME_US * CLK_MHZ < 1) ? 1 : PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYC = (ERASE_TIME_US * CLK_MHZ < 1) ? 1 : ERASE_TIME_US * CLK_MHZ;
   localparam logic [TIMER_W-1:0] PROG_LOAD  = TIMER_W'(PROG_CYC - 1);
   localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_CYC - 1);
   localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
   localparam logic [HOLD_AW-1:0] HOLD_LAST  = HOLD_AW'(HOLD_N - 1);

   typedef enum logic [1:0] {
      LW_IDLE,                                     // no long write
      LW_STREAM,                                   // holding bytes to array
      LW_TIMED                                     // waiting on timer
   } fsps_lw_state_t;

   // ************************************************************
   // storage
   // ************************************************************
   logic [PTR_W-1:0]   table_pointer_r;                   // table_pointer
   logic [7:0]         tblLatch_r;                 // table_latch
   logic [7:0]         holdMem [HOLD_N];           // holding registers
   logic               eraseSel_r;                 // erase-select
   logic               write_error_flag_r;                    // write_error_flag
   logic               write_enable_bit_r;                     // write_enable_bit
   logic               wrStart_r;                  // write-start
   logic [1:0]         keyStage_r;                 // 0 none, 1 first key, 2 both
   fsps_lw_state_t     lwState_r;                  // long write state
   logic [HOLD_AW-1:0] streamIdx_r;                // byte being streamed
   logic [TIMER_W-1:0] timer_r;                    // long write timer, program or erase
   logic               rdPend_r;                   // table read awaiting data
   logic               rdHiSel_r;                  // byte select of that read

   // ************************************************************
   // decode
   // ************************************************************
   logic               ctrlWr;                     // write to control register
   logic               keyWr;                      // write to key register
   logic               startOk;                    // legal long write start
   logic               startBad;                   // refused start attempt
   logic               lwDone;                     // timer expiry
   logic               tblGo;                      // table op accepted
   logic [PTR_W-1:0]   effPtr;                     // pointer used by table op
   logic [PTR_W-1:0]   postPtr;                    // pointer after table op

   assign ctrlWr   = regWr && (regAddr == REG_CTRL);
   assign keyWr    = regWr && (regAddr == REG_KEY);
   // the start must follow both keys with no other write between them
   assign startOk  = ctrlWr && regWrData[CTRL_WR_START] && !wrStart_r
                     && (keyStage_r == 2'h2) && write_enable_bit_r
                     && regWrData[CTRL_WR_EN];
   assign startBad = ctrlWr && regWrData[CTRL_WR_START] && !wrStart_r && !startOk;
   assign lwDone   = (lwState_r == LW_TIMED) && (timer_r == TIMER_ZERO);
   // table ops are dropped while stalled, the core cannot issue them then
   assign tblGo    = (tblOp.rd || tblOp.wr) && (lwState_r == LW_IDLE);

   // pointer arithmetic only on the low 21 bits, bit 21 is kept
   always_comb begin
      effPtr  = table_pointer_r;
      postPtr = table_pointer_r;
      unique case (tblOp.mode)
         PTR_KEEP: begin
            postPtr = table_pointer_r;
         end
         PTR_POST_INC: begin
            postPtr = {table_pointer_r[PTR_W-1], table_pointer_r[PTR_UPD_W-1:0] + PTR_UPD_W'(1)};
         end
         PTR_POST_DEC: begin
            postPtr = {table_pointer_r[PTR_W-1], table_pointer_r[PTR_UPD_W-1:0] - PTR_UPD_W'(1)};
         end
         PTR_PRE_INC: begin
            effPtr  = {table_pointer_r[PTR_W-1], table_pointer_r[PTR_UPD_W-1:0] + PTR_UPD_W'(1)};
            postPtr = effPtr;
         end
      endcase
   end

   // ************************************************************
   // table pointer
   // ************************************************************
   // bus writes win over a table op in the same cycle; the core never does both
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         table_pointer_r <= '0;
      end else if (regWr && regAddr == REG_PTR_LOW) begin
         table_pointer_r[7:0] <= regWrData;
      end else if (regWr && regAddr == REG_PTR_HIGH) begin
         table_pointer_r[15:8] <= regWrData;
      end else if (regWr && regAddr == REG_PTR_UPPER) begin
         table_pointer_r[PTR_W-1:16] <= regWrData[PTR_UP_W-1:0];
      end else if (tblGo) begin
         table_pointer_r <= postPtr;
      end
   end

   // ************************************************************
   // table read: word fetch, then byte select into the latch
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flashRdEn_r   <= 1'b0;
         flashRdAddr_r <= '0;
         rdPend_r      <= 1'b0;
         rdHiSel_r     <= 1'b0;
      end else begin
         flashRdEn_r <= tblGo && tblOp.rd;
         rdPend_r    <= tblGo && tblOp.rd;
         if (tblGo && tblOp.rd) begin
            flashRdAddr_r <= effPtr[PTR_W-1:1];
            rdHiSel_r     <= effPtr[0];
         end
      end
   end

   // latch takes the fetched byte or a software write
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tblLatch_r <= '0;
      end else if (rdPend_r) begin
         tblLatch_r <= rdHiSel_r ? flashRdData[15:8] : flashRdData[7:0];
      end else if (regWr && regAddr == REG_LATCH) begin
         tblLatch_r <= regWrData;
      end
   end

   // ************************************************************
   // holding registers
   // ************************************************************
   // no reset and no clear after programming, stale bytes stay until overwritten
   always_ff @(posedge sys_clk) begin
      if (tblGo && tblOp.wr) begin
         holdMem[effPtr[HOLD_AW-1:0]] <= tblLatch_r;
      end
   end

   // ************************************************************
   // unlock key tracking
   // ************************************************************
   // any other register write breaks the sequence
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         keyStage_r <= 2'h0;
      end else if (keyWr && regWrData == KEY_FIRST) begin
         keyStage_r <= 2'h1;
      end else if (keyWr && regWrData == KEY_SECOND && keyStage_r == 2'h1) begin
         keyStage_r <= 2'h2;
      end else if (regWr) begin
         keyStage_r <= 2'h0;
      end
   end

   // ************************************************************
   // control bits
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         write_enable_bit_r     <= 1'b0;
         eraseSel_r <= 1'b0;
      end else if (ctrlWr && lwState_r == LW_IDLE) begin
         write_enable_bit_r     <= regWrData[CTRL_WR_EN];
         eraseSel_r <= regWrData[CTRL_ERASE_SEL];
      end else if (lwDone && eraseSel_r) begin
         eraseSel_r <= 1'b0;                         // erase completion clears it
      end
   end

   // write-start: software may only set it, hardware clears on completion;
   // abort wins so a start cut in the same cycle leaves no stuck bit
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrStart_r <= 1'b0;
      end else if (lwDone || abortReq) begin
         wrStart_r <= 1'b0;
      end else if (startOk) begin
         wrStart_r <= 1'b1;
      end
   end

   // error flag: set at start, cleared by a clean finish or an idle control write; an abort leaves
   // it set. a set event beats a software clear in the same cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         write_error_flag_r <= 1'b0;
      end else if (startOk || startBad) begin
         write_error_flag_r <= 1'b1;
      end else if (lwDone) begin
         write_error_flag_r <= 1'b0;
      end else if (ctrlWr && lwState_r == LW_IDLE) begin
         write_error_flag_r <= regWrData[CTRL_WR_ERR];
      end
   end

   // ************************************************************
   // long write sequencer
   // ************************************************************
   // only two targets exist: one 64-byte row or one 1024-byte block
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lwState_r   <= LW_IDLE;
         streamIdx_r <= '0;
         timer_r     <= '0;
      end else if (abortReq) begin
         lwState_r <= LW_IDLE;
         timer_r   <= '0;
      end else begin
         unique case (lwState_r)
            LW_IDLE: begin
               streamIdx_r <= '0;
               if (startOk && regWrData[CTRL_ERASE_SEL]) begin
                  lwState_r <= LW_TIMED;
                  timer_r   <= ERASE_LOAD;
               end else if (startOk) begin
                  lwState_r <= LW_STREAM;
               end
            end
            LW_STREAM: begin
               streamIdx_r <= streamIdx_r + HOLD_AW'(1);
               if (streamIdx_r == HOLD_LAST) begin
                  lwState_r <= LW_TIMED;
                  timer_r   <= PROG_LOAD;
               end
            end
            LW_TIMED: begin
               if (timer_r == TIMER_ZERO) begin
                  lwState_r <= LW_IDLE;
               end else begin
                  timer_r <= timer_r - TIMER_W'(1);
               end
            end
         endcase
      end
   end

   // array commands: erase addresses the block only, low ten bits forced zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flashWr_r <= '0;
      end else begin
         flashWr_r.prog  <= (lwState_r == LW_STREAM) && !abortReq;
         flashWr_r.erase <= startOk && regWrData[CTRL_ERASE_SEL] && !abortReq;
         if (startOk && regWrData[CTRL_ERASE_SEL]) begin
            flashWr_r.addr <= {table_pointer_r[PTR_W-1:ERASE_LSB], ERASE_LSB'(0)};
            flashWr_r.data <= '0;
         end else if (lwState_r == LW_STREAM) begin
            flashWr_r.addr <= {table_pointer_r[PTR_W-1:HOLD_AW], streamIdx_r};
            flashWr_r.data <= holdMem[streamIdx_r];
         end
      end
   end

   // stall from the start write until the timer or an abort ends the cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         coreStall_r <= 1'b0;
      end else if (abortReq || lwDone) begin
         coreStall_r <= 1'b0;
      end else if (startOk) begin
         coreStall_r <= 1'b1;
      end
   end

   // ************************************************************
   // register read port, data one cycle after the strobe
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData_r <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            REG_PTR_LOW:   regRdData_r <= table_pointer_r[7:0];
            REG_PTR_HIGH:  regRdData_r <= table_pointer_r[15:8];
            REG_PTR_UPPER: regRdData_r <= {2'h0, table_pointer_r[PTR_W-1:16]};
            REG_LATCH:     regRdData_r <= tblLatch_r;
            REG_CTRL:      regRdData_r <= {3'h0, eraseSel_r, write_error_flag_r, write_enable_bit_r, wrStart_r, 1'b0};
            default:       regRdData_r <= '0;            // key and unmapped read zero
         endcase
      end else begin
         regRdData_r <= '0;
      end
   end

endmodule : fsps_sequencer
`default_nettype wire

// [test/fsps_flash_model.sv]
// partner: program flash array that answers a word read in its enable cycle
`default_nettype none
module fsps_flash_model (
   // word read request
   input  wire logic        flashRdEn_r,
   input  wire logic [20:0] flashRdAddr_r,
   // word returned
   output wire logic [15:0] flashRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // array content is a fixed pattern of the word address
   // ************************************************************
   wire logic [15:0] word = {flashRdAddr_r[7:0] ^ 8'h3c, flashRdAddr_r[15:8] ^ flashRdAddr_r[7:0]};
   // outside the enable cycle the word is inverted, so a late sample never matches
   assign flashRdData = flashRdEn_r ? word : ~word;
endmodule : fsps_flash_model
`default_nettype wire

// [test/fsps_sequencer_asserts.sv]
// checker: port-level assertions for the flash self-program sequencer
`default_nettype none
module fsps_sequencer_asserts
   import fsps_pkg::*;
(
   // clock and reset
   input wire logic               sys_clk,
   input wire logic               arst_n,
   // register port
   input wire logic [REG_AW-1:0]  regAddr,
   input wire logic [7:0]         regWrData,
   input wire logic               regWr,
   input wire logic               regRd,
   input wire logic [7:0]         regRdData_r,
   // core and array side
   input wire fsps_tbl_op_t       tblOp,
   input wire logic               coreStall_r,
   input wire logic               abortReq,
   input wire logic               flashRdEn_r,
   input wire logic [WORD_AW-1:0] flashRdAddr_r,
   input wire logic [15:0]        flashRdData,
   input wire fsps_flash_wr_t     flashWr_r
);
   // ************************************************************
   // helpers
   // ************************************************************
   logic [7:0] progCnt_r;                 // length of the running program burst
   wire  logic keyOne = regWr && regAddr == REG_KEY && regWrData == KEY_FIRST;
   wire  logic keyTwo = regWr && regAddr == REG_KEY && regWrData == KEY_SECOND;
   wire  logic goReq  = regWr && regAddr == REG_CTRL && regWrData[CTRL_WR_START] && !coreStall_r;
   // counts burst cycles; cleared between bursts
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) progCnt_r <= 8'h0;
      else         progCnt_r <= flashWr_r.prog ? progCnt_r + 8'h1 : 8'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // full unlock: two keys back to back, then the start write
   sequence sUnlock;
      keyOne ##1 keyTwo ##1 (goReq && regWrData[CTRL_WR_EN]);
   endsequence
   // ************************************************************
   // assertions
   // ************************************************************
   a_unlock_start: assert property (sUnlock |=> coreStall_r) else $error("start after keys did not stall");
   a_keys_required: assert property (goReq && !($past(keyTwo) && $past(keyOne, 2)) |=> !coreStall_r)
      else $error("start without keys began a long write");
   a_write_enable_bit_required: assert property (goReq && !regWrData[CTRL_WR_EN] |=> !coreStall_r)
      else $error("start without write enable began a long write");
   a_erase_block: assert property (flashWr_r.erase |-> flashWr_r.addr[9:0] == 10'h0 && coreStall_r)
      else $error("erase not on a block base");
   a_prog_burst: assert property ($fell(flashWr_r.prog) && !$past(abortReq) |-> progCnt_r == 8'd64)
      else $error("program burst not 64 bytes");
   a_prog_step: assert property (flashWr_r.prog && $past(flashWr_r.prog) |-> flashWr_r.addr == $past(flashWr_r.addr) + 22'h1)
      else $error("program address did not step");
   a_stall_ends: assert property ($rose(coreStall_r) |-> ##[1:400] !coreStall_r)
      else $error("long write not ended by timer");
   a_stall_no_read: assert property (coreStall_r && $past(coreStall_r) |-> !flashRdEn_r)
      else $error("array read during long write");
   a_read_answer: assert property (tblOp.rd && !tblOp.wr && !coreStall_r |=> flashRdEn_r)
      else $error("table read gave no array read");
   a_no_array_idle: assert property (!coreStall_r |-> !flashWr_r.prog && !flashWr_r.erase)
      else $error("array written outside a long write");
   a_rdata_idle: assert property (!$past(regRd) |-> regRdData_r == 8'h0) else $error("read data outside answer cycle");
endmodule : fsps_sequencer_asserts
bind fsps_sequencer fsps_sequencer_asserts i_fsps_sequencer_asserts (.*);
`default_nettype wire

// [test/fsps_sequencer_tb.sv]
// testbench: self-checking run of the flash self-program sequencer
`default_nettype none
module fsps_sequencer_tb
   import fsps_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // stimulus, observed ports and reference state
   // ************************************************************
   logic sys_clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, abortReq = 1'b0;
   logic [2:0]  regAddr = 3'h0;
   logic [7:0]  regWrData = 8'h0, regRdData_r;
   fsps_tbl_op_t tblOp = 4'h0;
   logic coreStall_r, flashRdEn_r;
   logic [20:0] flashRdAddr_r;
   logic [15:0] flashRdData;
   fsps_flash_wr_t flashWr_r;
   int n_fail = 0, check_count = 0, progIdx = 0, nErase = 0, i, j;
   logic [31:0] seed = 32'had8b, r;
   logic [21:0] p, expBase;                 // reference pointer, burst base
   logic [7:0]  hold [64];                  // reference holding registers
   always #10 sys_clk = ~sys_clk;
   // short timers keep a program write near 114 cycles and an erase near 50
   fsps_sequencer #(.PROG_TIME_US(1), .ERASE_TIME_US(1)) i_fsps_sequencer (.*);
   fsps_flash_model i_fsps_flash_model (.*);
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic conclude();
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [7:0] romByte(input logic [21:0] a);
      logic [15:0] w;
      w = {a[8:1] ^ 8'h3c, a[16:9] ^ a[8:1]};
      return a[0] ? w[15:8] : w[7:0];
   endfunction : romByte
   function automatic logic [21:0] inc(input logic [21:0] a);
      return {a[21], a[20:0] + 21'h1};      // bit 21 never moves
   endfunction : inc
   // one bus cycle: every input but abortReq and arst_n assigned once, then the taking edge
   task automatic drv(input logic w, rr, input logic [2:0] a, input logic [7:0] d, input fsps_tbl_op_t op);
      regWr <= w;
      regRd <= rr;
      regAddr <= a;
      regWrData <= d;
      tblOp <= op;
      @(posedge sys_clk);
   endtask : drv
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      drv(1'b1, 1'b0, a, d, 4'h0);
   endtask : wr
   // read data stand in the cycle after the strobe only
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      drv(1'b0, 1'b1, a, 8'h0, 4'h0);
      #1 chk(regRdData_r & m, e);
   endtask : rd
   task automatic setp(input logic [21:0] a);
      wr(REG_PTR_LOW, a[7:0]);
      wr(REG_PTR_HIGH, a[15:8]);
      wr(REG_PTR_UPPER, {2'h0, a[21:16]});
      p = a;
   endtask : setp
   // table read; latch settles two edges after the op
   task automatic tread(input fsps_ptr_mode_t m);
      logic [21:0] e;
      drv(1'b0, 1'b0, 3'h0, 8'h0, {1'b1, 1'b0, m});
      if (m == PTR_PRE_INC) p = inc(p);
      e = p;
      if (m == PTR_POST_INC) p = inc(p);
      if (m == PTR_POST_DEC) p = {p[21], p[20:0] - 21'h1};
      drv(1'b0, 1'b0, 3'h0, 8'h0, 4'h0);
      drv(1'b0, 1'b0, 3'h0, 8'h0, 4'h0);
      rd(REG_LATCH, romByte(e));
   endtask : tread
   // control pre-write, keys (2 = broken by a write between), start
   task automatic lw(input logic [7:0] pre, input int keys, input logic [7:0] st, input logic exp);
      wr(REG_CTRL, pre);
      if (keys > 0) wr(REG_KEY, KEY_FIRST);
      if (keys > 1) wr(REG_LATCH, 8'h0);
      if (keys > 0) wr(REG_KEY, KEY_SECOND);
      wr(REG_CTRL, st);
      #1 chk(coreStall_r, exp);
   endtask : lw
   task automatic waitIdle();
      for (i = 0; i < 400 && coreStall_r !== 1'b0; i++) drv(1'b0, 1'b0, 3'h0, 8'h0, 4'h0);
      if (coreStall_r !== 1'b0) begin
         n_fail++;
         conclude();
      end
   endtask : waitIdle
   // array writes compared as they stream out
   always @(posedge sys_clk) begin
      if (flashWr_r.prog) begin
         chk(flashWr_r.addr, {expBase[21:6], progIdx[5:0]});
         chk(flashWr_r.data, hold[flashWr_r.addr[5:0]]);
         progIdx++;
      end
      if (flashWr_r.erase) begin
         chk(flashWr_r.addr, {expBase[21:10], 10'h0});
         nErase++;
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      rd(REG_CTRL, 8'h0);
      rd(REG_KEY, 8'h0);
      rd(3'h6, 8'h0);
      r = xs();
      setp(r[21:0]);
      for (j = 0; j < 8; j++) tread(fsps_ptr_mode_t'(j[1:0]));
      setp(22'h3ffffe);
      for (j = 0; j < 4; j++) tread(PTR_POST_INC);
      // fill holding registers from base minus one, pre-increment
      r = xs();
      expBase = {r[21:6] | 16'h1, 6'h0};
      setp(expBase - 22'h1);
      for (j = 0; j < 64; j++) begin
         r = xs();
         wr(REG_LATCH, r[7:0]);
         drv(1'b0, 1'b0, 3'h0, 8'h0, {1'b0, 1'b1, PTR_PRE_INC});
         p = inc(p);
         hold[p[5:0]] = r[7:0];
         #1 chk(coreStall_r, 1'b0);
      end
      // program two fresh rows, the second from retained holding bytes
      for (j = 0; j < 2; j++) begin
         progIdx = 0;
         expBase = expBase + 22'(j * 64);
         setp(expBase);
         lw(8'h04, 1, 8'h06, 1'b1);
         waitIdle();
         chk(progIdx, 64);
         rd(REG_CTRL, 8'h04);
      end
      r = xs();
      setp(r[21:0]);
      expBase = p;
      lw(8'h14, 1, 8'h16, 1'b1);
      waitIdle();
      chk(nErase, 1);
      rd(REG_CTRL, 8'h04);
      // refused starts: no enable, no keys, keys broken apart
      progIdx = 0;
      lw(8'h00, 1, 8'h02, 1'b0);
      rd(REG_CTRL, 8'h08);
      lw(8'h04, 0, 8'h06, 1'b0);
      rd(REG_CTRL, 8'h0c);
      lw(8'h04, 2, 8'h06, 1'b0);
      chk(progIdx + nErase, 1);
      // abort mid-write, with a table read refused while stalled
      lw(8'h04, 1, 8'h06, 1'b1);
      drv(1'b0, 1'b0, 3'h0, 8'h0, {1'b1, 1'b0, PTR_KEEP});
      abortReq <= 1'b1;
      drv(1'b0, 1'b0, 3'h0, 8'h0, 4'h0);
      abortReq <= 1'b0;
      waitIdle();
      rd(REG_CTRL, 8'h08, 8'h0a);
      conclude();
   end
endmodule : fsps_sequencer_tb
`default_nettype wire
